// >>> hw/ptb_trace_unit.sv
// program flow trace buffer: records branch and exception flow changes
// assumes an apb master, a trace interface and a held processor request
`default_nettype none
module ptb_trace_unit
  import ptb_pkg::*;
#(
  parameter int SRAM_AW = 10,
  parameter logic [31:0] SRAM_BASE = 32'h2000_0000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ptb_trace_t trace,
  input wire ptb_cpu_req_t cpu,
  output logic cpuReady,
  output logic [31:0] cpuRdata,
  output logic cpuRvalid,
  output logic haltReq,
  output logic traceActive,
  output logic [31:0] romBaseAddr
);
  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  localparam int PW = SRAM_AW + 2;
  // refuse sram sizes that the pointer fields cannot hold
  if (SRAM_AW < 2 || SRAM_AW > 30) begin : g_bad_aw
    $error("ptb_trace_unit: SRAM_AW out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  ptb_state_t state_q, state_d; // record writer
  logic [PW-1:0] posPtr_q, posPtr_d; // byte write pointer
  logic wrap_q, wrap_d; // pointer came back to start
  logic en_q, en_d; // trace enable
  logic [MASK_W-1:0] mask_q, mask_d; // buffer size code
  logic [PW-1:0] wm_q, wm_d; // watermark byte address
  logic stop_q, stop_d; // stop_at_limit
  logic halt_q, halt_d; // halt_at_limit
  logic [31:0] word0_q, word0_d; // record word carrying source
  logic [31:0] word1_q, word1_d; // record word carrying target
  logic [31:0] prdata_q; // apb read holding register
  logic haltReq_q; // one cycle halt request
  logic cpuRvalid_q; // processor read data valid

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic [11:0] ofs;
  logic inBlk, isPos, isMst, isFlow, isBase, known;
  logic apbWr, apbRdSetup, wrPos, wrMst, wrFlow;
  assign ofs = paddr[PTB_BLK_LSB-1:0];
  assign inBlk = paddr[31:PTB_BLK_LSB] == PTB_REG_BASE[31:PTB_BLK_LSB];
  assign isPos = inBlk && ofs == OFS_POSITION;
  assign isMst = inBlk && ofs == OFS_MASTER;
  assign isFlow = inBlk && ofs == OFS_FLOW;
  assign isBase = inBlk && ofs == OFS_BASE;
  assign known = isPos || isMst || isFlow || isBase;
  assign apbWr = psel && penable && pwrite && known;
  assign apbRdSetup = psel && !penable && !pwrite;
  assign wrPos = apbWr && isPos;
  assign wrMst = apbWr && isMst;
  assign wrFlow = apbWr && isFlow;
  // zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata = prdata_q;
  // base published for the rom table
  assign romBaseAddr = PTB_REG_BASE;

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] posWord, mstWord, flowWord, rdMux;
  assign posWord = {{(32-PW){1'b0}}, posPtr_q[PW-1:PTR_LSB], wrap_q, 2'b00};
  assign mstWord = {en_q, {(31-MASK_W){1'b0}}, mask_q};
  // watermark with stop and halt bits
  assign flowWord = {{(32-PW){1'b0}}, wm_q[PW-1:PTR_LSB], 1'b0, halt_q, stop_q};
  assign rdMux = isPos ? posWord :
                 isMst ? mstWord :
                 isFlow ? flowWord :
                 isBase ? SRAM_BASE : RST_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // buffer window arithmetic
  logic [PW-1:0] wrapMask, stepPtr, nextPtr;
  logic wrapHit, limitHit;
  // size from mask, location from pointer
  assign wrapMask = ~({PW{1'b1}} << ((MASK_W+1)'(mask_q) + (MASK_W+1)'(MASK_BIAS)));
  assign stepPtr = posPtr_q + PW'(REC_BYTES);
  assign nextPtr = (posPtr_q & ~wrapMask) | (stepPtr & wrapMask);
  assign wrapHit = (stepPtr & wrapMask) == '0;
  assign limitHit = nextPtr == wm_q;

  ////////////////////////////////////////////////////////////////////////////
  // trace capture
  logic evt, stopNow, accept, lastWord;
  assign evt = trace.branch || trace.excEntry;
  assign lastWord = state_q == PTB_WR1;
  assign stopNow = lastWord && stop_q && limitHit;
  assign accept = evt && en_q && !stopNow && state_q != PTB_WR0;
  assign traceActive = en_q;

  ////////////////////////////////////////////////////////////////////////////
  // sram arbitration
  logic traceWe, memWe, memRe;
  logic [SRAM_AW-1:0] memAddr, traceAddr;
  logic [31:0] memWdata;
  logic [PW-1:0] word1Ptr;
  assign traceWe = state_q != PTB_IDLE;
  assign word1Ptr = posPtr_q + PW'(WORD_BYTES);
  assign traceAddr = lastWord ? word1Ptr[PW-1:2] : posPtr_q[PW-1:2];
  assign cpuReady = cpu.req && !traceWe;
  // processor access when no trace write
  assign memWe = traceWe || (cpuReady && cpu.we);
  assign memRe = cpuReady && !cpu.we;
  assign memAddr = traceWe ? traceAddr : cpu.addr[PW-1:2];
  assign memWdata = !traceWe ? cpu.wdata : lastWord ? word1_q : word0_q;
  assign cpuRvalid = cpuRvalid_q;
  assign haltReq = haltReq_q;

  // shared storage
  ptb_sram #(
    .AW(SRAM_AW),
    .DW(32)
  ) u_sram (
    .clk(clk),
    .rstn(rstn),
    .we(memWe),
    .re(memRe),
    .addr(memAddr),
    .wdata(memWdata),
    .rdata(cpuRdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // record writer next state
  always_comb begin
    state_d = state_q;
    word0_d = word0_q;
    word1_d = word1_q;
    unique case (state_q)
      PTB_IDLE: begin
        if (accept) begin
          state_d = PTB_WR0;
        end
      end
      PTB_WR0: begin
        state_d = PTB_WR1;
      end
      PTB_WR1: begin
        state_d = accept ? PTB_WR0 : PTB_IDLE;
      end
      default: begin
        state_d = PTB_IDLE;
      end
    endcase
    // latch source with exception flag, then target
    if (accept) begin
      word0_d = {trace.srcPc[31:1], trace.excEntry};
      word1_d = {trace.dstPc[31:1], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register next values
  always_comb begin
    posPtr_d = posPtr_q;
    wrap_d = wrap_q;
    en_d = en_q;
    mask_d = mask_q;
    wm_d = wm_q;
    stop_d = stop_q;
    halt_d = halt_q;
    // pointer written by software, low bits forced to record alignment
    if (wrPos) begin
      posPtr_d = {pwdata[PW-1:PTR_LSB], {PTR_LSB{1'b0}}};
      wrap_d = pwdata[POS_WRAP_BIT];
    end else if (lastWord) begin
      posPtr_d = nextPtr;
    end
    // wrap flag set wins over a clearing write
    if (lastWord && wrapHit) begin
      wrap_d = 1'b1;
    end
    if (stopNow) begin
      en_d = 1'b0;
    end
    if (wrMst) begin
      en_d = pwdata[MST_EN_BIT];
      mask_d = pwdata[MASK_W-1:0];
    end
    if (wrFlow) begin
      wm_d = {pwdata[PW-1:PTR_LSB], {PTR_LSB{1'b0}}};
      stop_d = pwdata[FLOW_STOP_BIT];
      halt_d = pwdata[FLOW_HALT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= PTB_IDLE;
      posPtr_q <= '0;
      wrap_q <= 1'b0;
      en_q <= 1'b0;
      mask_q <= RST_MASK;
      wm_q <= '0;
      stop_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      posPtr_q <= posPtr_d;
      wrap_q <= wrap_d;
      en_q <= en_d;
      mask_q <= mask_d;
      wm_q <= wm_d;
      stop_q <= stop_d;
      halt_q <= halt_d;
    end
  end

  // record words and apb read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word0_q <= RST_WORD;
      word1_q <= RST_WORD;
      prdata_q <= RST_WORD;
    end else begin
      word0_q <= word0_d;
      word1_q <= word1_d;
      if (apbRdSetup) begin
        prdata_q <= rdMux;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      haltReq_q <= 1'b0;
      cpuRvalid_q <= 1'b0;
    end else begin
      haltReq_q <= lastWord && halt_q && limitHit;
      cpuRvalid_q <= memRe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // a record occupies two consecutive write cycles
  sequence seqRecord;
    state_q == PTB_WR0 && memWe ##1 state_q == PTB_WR1 && memWe;
  endsequence

  // disabled events leave the writer idle
  a_no_trace_off: assert property (
    (state_q == PTB_IDLE && evt && !en_q) |=> state_q == PTB_IDLE)
    else $error("record started while disabled");

  // accepted event writes both words next
  a_event_record: assert property (
    (state_q == PTB_IDLE && evt && en_q) |=> seqRecord)
    else $error("event did not produce a two word record");

  // words land at pointer and pointer plus four
  a_word_addr: assert property (
    state_q == PTB_WR0 |-> memAddr == posPtr_q[PW-1:2] ##1 memAddr == $past(word1Ptr[PW-1:2]))
    else $error("record words at wrong addresses");

  // processor is stalled during trace writes
  a_trace_priority: assert property (
    (cpu.req && traceWe) |-> !cpuReady && !memRe && memWe && memAddr == traceAddr)
    else $error("processor granted during trace write");

  // processor read returns data next cycle when free
  a_cpu_served: assert property (
    (cpu.req && !cpu.we && !traceWe) |-> cpuReady ##1 cpuRvalid)
    else $error("processor not served when sram free");

  // pointer steps one record after the second word
  a_ptr_advance: assert property (
    (lastWord && !wrPos) |=> posPtr_q == $past(nextPtr))
    else $error("write pointer did not advance");

  // pointer stays inside the buffer window
  a_ptr_window: assert property (
    (lastWord && !wrPos && !wrMst) |=> (posPtr_q & ~wrapMask) == $past(posPtr_q & ~wrapMask))
    else $error("pointer left the buffer window");

  // wrap flag after returning to window start
  a_wrap_flag: assert property (
    (lastWord && wrapHit) |=> wrap_q)
    else $error("wrap flag not set");

  // tracing stops at watermark
  a_auto_stop: assert property (
    (stopNow && !wrMst) |=> !en_q ##1 state_q != PTB_WR0)
    else $error("tracing continued past watermark");

  // halt request pulse at watermark
  a_halt_pulse: assert property (
    (lastWord && halt_q && limitHit) |=> haltReq ##1 !haltReq)
    else $error("halt request missing");

  // enable write takes effect at once
  a_enable_write: assert property (
    wrMst |=> en_q == $past(pwdata[MST_EN_BIT]))
    else $error("enable write not applied");

  // base register read returns sram location
  a_base_read: assert property (
    (apbRdSetup && isBase) |=> prdata == SRAM_BASE)
    else $error("base register wrong");

  // foreign offsets inside block are refused
  a_unmapped_err: assert property (
    (psel && penable && inBlk && !known) |-> pslverr)
    else $error("unmapped offset not refused");
endmodule // ptb_trace_unit
`default_nettype wire

// >>> hw/ptb_pkg.sv
// constants, types and register map of the program flow trace buffer
// assumes one system clock and an active low asynchronous reset
`default_nettype none
package ptb_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register block placement and offsets
  localparam logic [31:0] PTB_REG_BASE = 32'h4100_6000;
  localparam int PTB_BLK_LSB = 12;
  localparam logic [11:0] OFS_POSITION = 12'h000;
  localparam logic [11:0] OFS_MASTER = 12'h004;
  localparam logic [11:0] OFS_FLOW = 12'h008;
  localparam logic [11:0] OFS_BASE = 12'h00C;
  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int POS_WRAP_BIT = 2;
  localparam int PTR_LSB = 3;
  localparam int MST_EN_BIT = 31;
  localparam int MASK_W = 5;
  localparam int FLOW_STOP_BIT = 0;
  localparam int FLOW_HALT_BIT = 1;
  // smallest buffer is two to the power MASK_BIAS bytes
  localparam int MASK_BIAS = 4;
  localparam int REC_BYTES = 8;
  localparam int WORD_BYTES = 4;
  // reset values
  localparam logic [MASK_W-1:0] RST_MASK = 5'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  ////////////////////////////////////////////////////////////////////////////
  // record writer states, gray along idle, word0, word1
  typedef enum logic [1:0] {
    PTB_IDLE = 2'b00,
    PTB_WR0 = 2'b01,
    PTB_WR1 = 2'b11
  } ptb_state_t;
  // one report from the core trace interface
  typedef struct packed {
    logic branch;
    logic excEntry;
    logic [31:0] srcPc;
    logic [31:0] dstPc;
  } ptb_trace_t;
  // one processor request to the shared sram
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ptb_cpu_req_t;
endpackage : ptb_pkg
`default_nettype wire

// >>> hw/ptb_sram.sv
// single port sram shared by trace writes and processor accesses
// assumes the caller arbitrates; read data come from a register
`default_nettype none
module ptb_sram #(
  parameter int AW = 10,
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // storage array, not reset
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[addr];
    end
  end
endmodule // ptb_sram
`default_nettype wire

// >>> hw/ptb_pkg_dummy_end.sv
`default_nettype none
`default_nettype wire

// >>> bench/ptb_core_model.sv
// processor side model: flow change reports and shared sram requests
// assumes the trace unit samples both interfaces on the rising clk edge
`default_nettype none
module ptb_core_model
  import ptb_pkg::*;
(
  input wire logic clk,
  input wire logic cpuReady,
  input wire logic [31:0] cpuRdata,
  input wire logic cpuRvalid,
  output var ptb_trace_t trace,
  output var ptb_cpu_req_t cpu
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // quiet interfaces from time zero
  initial begin
    trace = '0;
    cpu = '0;
  end
  // one flow change, valid for a single cycle
  task automatic flow(input logic br, input logic ex, input logic [31:0] s,
                      input logic [31:0] d);
    trace <= '{branch: br, excEntry: ex, srcPc: s, dstPc: d};
    @(posedge clk);
    // released pcs flip so stale values are never mistaken for data
    trace <= '{branch: 1'b0, excEntry: 1'b0, srcPc: ~s, dstPc: ~d};
  endtask
  // debugger path to sram
  // word access held until granted; stalls counts refused edges
  task automatic access(input logic we, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output int stalls);
    stalls = 0;
    cpu <= '{req: 1'b1, we: we, addr: a, wdata: wd};
    @(posedge clk);
    while (cpuReady !== 1'b1) begin
      stalls++;
      @(posedge clk);
    end
    cpu <= '{req: 1'b0, we: ~we, addr: ~a, wdata: ~wd};
    @(posedge clk);
    // read data arrive one cycle after the grant
    rd = (cpuRvalid === 1'b1) ? cpuRdata : 32'hdead_beef;
  endtask
endmodule // ptb_core_model
`default_nettype wire

// >>> bench/test_program_flow_trace_buffer.sv
// testbench of the trace unit: apb register tests and trace traffic
// assumes the core model stands in for the processor and debugger
`default_nettype none
module test_program_flow_trace_buffer
  import ptb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SRAM_AT = 32'h2000_0000;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic cpuReady, cpuRvalid, haltReq, traceActive;
  logic [31:0] paddr, pwdata, prdata, cpuRdata, romBaseAddr, rd;
  ptb_trace_t trace;
  ptb_cpu_req_t cpu;
  int nMismatch, samplesChecked, haltSeen, st;
  ////////////////////////////////////////////////////////////////////////////
  ptb_trace_unit #(.SRAM_AW(10), .SRAM_BASE(SRAM_AT)) dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trace(trace), .cpu(cpu), .cpuReady(cpuReady),
    .cpuRdata(cpuRdata), .cpuRvalid(cpuRvalid), .haltReq(haltReq),
    .traceActive(traceActive), .romBaseAddr(romBaseAddr));
  ptb_core_model core (
    .clk(clk), .cpuReady(cpuReady), .cpuRdata(cpuRdata), .cpuRvalid(cpuRvalid),
    .trace(trace), .cpu(cpu));
  ////////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counts halt request pulses
  always @(posedge clk) begin
    if (haltReq === 1'b1) haltSeen <= haltSeen + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    apb(1'b1, PTB_REG_BASE | 32'(ofs), d);
  endtask
  task automatic rdchk(input logic [11:0] ofs, input logic [31:0] exp);
    apb(1'b0, PTB_REG_BASE | 32'(ofs), 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic rdSram(input logic [31:0] a, input logic [31:0] exp);
    core.access(1'b0, a, 32'h0000_0000, rd, st);
    chk(rd, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    nMismatch++;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {nMismatch, samplesChecked, haltSeen} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // reset values, read-only base and decode errors
    rdchk(OFS_POSITION, RST_WORD);
    rdchk(OFS_MASTER, RST_WORD);
    rdchk(OFS_FLOW, RST_WORD);
    wr(OFS_BASE, 32'h0000_0000);
    rdchk(OFS_BASE, SRAM_AT);
    chk(32'(err), 32'h0000_0000);
    chk(romBaseAddr, 32'h4100_6000);
    rdchk(12'h010, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, 32'h4100_7000, 32'hffff_ffff);
    chk(32'(err), 32'h0000_0001);
    // flow changes while disabled are dropped
    core.flow(1'b1, 1'b0, 32'h0000_0777, 32'h0000_0999);
    repeat (3) @(posedge clk);
    rdchk(OFS_POSITION, 32'h0000_0000);
    // 16 byte window at 0x40, branch then exception two cycles apart
    wr(OFS_POSITION, 32'h0000_0040);
    wr(OFS_MASTER, 32'h8000_0000);
    chk(32'(traceActive), 32'h0000_0001);
    core.flow(1'b1, 1'b0, 32'h0000_1235, 32'h0000_2001);
    @(posedge clk);
    core.flow(1'b0, 1'b1, 32'h0000_3003, 32'h0000_4005);
    repeat (3) @(posedge clk);
    rdchk(OFS_POSITION, 32'h0000_0044);
    rdSram(32'h0000_0040, 32'h0000_1234);
    rdSram(32'h0000_0044, 32'h0000_2000);
    rdSram(32'h0000_0048, 32'h0000_3003);
    rdSram(32'h0000_004c, 32'h0000_4004);
    // third record overwrites the oldest after the wrap
    core.flow(1'b1, 1'b0, 32'h0000_5001, 32'h0000_6001);
    repeat (3) @(posedge clk);
    rdchk(OFS_POSITION, 32'h0000_004c);
    rdSram(32'h0000_0040, 32'h0000_5000);
    rdSram(32'h0000_0044, 32'h0000_6000);
    // stop by clearing enable
    wr(OFS_MASTER, 32'h0000_0000);
    chk(32'(traceActive), 32'h0000_0000);
    core.flow(1'b1, 1'b0, 32'h0000_0111, 32'h0000_0222);
    repeat (3) @(posedge clk);
    rdchk(OFS_POSITION, 32'h0000_004c);
    // processor write colliding with a record is stalled two cycles
    wr(OFS_MASTER, 32'h8000_0000);
    fork
      core.flow(1'b1, 1'b0, 32'h0000_7001, 32'h0000_8001);
      begin
        @(posedge clk);
        core.access(1'b1, 32'h0000_0100, 32'h1234_5678, rd, st);
      end
    join
    chk(32'(st), 32'h0000_0002);
    rdSram(32'h0000_0100, 32'h1234_5678);
    rdSram(32'h0000_0048, 32'h0000_7000);
    // watermark at 0x10 with stop and halt in a 32 byte window
    wr(OFS_MASTER, 32'h0000_0000);
    wr(OFS_POSITION, 32'h0000_0000);
    wr(OFS_FLOW, 32'h0000_0013);
    rdchk(OFS_FLOW, 32'h0000_0013);
    wr(OFS_MASTER, 32'h8000_0001);
    core.flow(1'b1, 1'b0, 32'h0000_0301, 32'h0000_0401);
    @(posedge clk);
    core.flow(1'b1, 1'b0, 32'h0000_0501, 32'h0000_0601);
    // one edge more so the halt pulse counter has taken its count
    repeat (4) @(posedge clk);
    chk(32'(traceActive), 32'h0000_0000);
    chk(32'(haltSeen), 32'h0000_0001);
    rdchk(OFS_MASTER, 32'h0000_0001);
    rdchk(OFS_POSITION, 32'h0000_0010);
    core.flow(1'b1, 1'b0, 32'h0000_0701, 32'h0000_0801);
    repeat (3) @(posedge clk);
    rdchk(OFS_POSITION, 32'h0000_0010);
    test_done;
  end
endmodule // test_program_flow_trace_buffer
`default_nettype wire
